// *** src/ats_defines.svh ***
// offsets, field positions, reset values and timing counts of the
// trigger and sample-time block; included by the package and the bench
`ifndef ATS_DEFINES_SVH
`define ATS_DEFINES_SVH

`define ATS_OFF_STATUS 12'h000
`define ATS_OFF_CTRL 12'h008
`define ATS_OFF_SMP_HI 12'h00C
`define ATS_OFF_SMP_LO 12'h010

`define ATS_INJ_SEL_LSB 12
`define ATS_INJ_EXT_EN_BIT 15
`define ATS_REG_SEL_LSB 17
`define ATS_REG_EXT_EN_BIT 20
`define ATS_INJ_SOFT_BIT 21
`define ATS_REG_SOFT_BIT 22
`define ATS_TEMP_EN_BIT 23

`define ATS_CTRL_RESET 32'h0000_0000
`define ATS_SMP_RESET 32'h0000_0000
`define ATS_SMP_HI_MASK 32'h00FF_FFFF
`define ATS_SMP_LO_MASK 32'h3FFF_FFFF
`define ATS_SW_CODE 3'h7

// pclk cycles per half converter clock period
`define ATS_HALF_PERIOD_CYC 12'h001
// sampling durations in half converter periods
`define ATS_SMP_HALF_0 12'h003
`define ATS_SMP_HALF_1 12'h00F
`define ATS_SMP_HALF_2 12'h01B
`define ATS_SMP_HALF_3 12'h039
`define ATS_SMP_HALF_4 12'h053
`define ATS_SMP_HALF_5 12'h06F
`define ATS_SMP_HALF_6 12'h08F
`define ATS_SMP_HALF_7 12'h1DF

`endif

// *** src/ats_pkg.sv ***
// types shared by the trigger and sample-time block
// assumes ats_defines.svh on the include path
`include "ats_defines.svh"

package ats_pkg;

  typedef struct packed {
    logic tim1_cc1;
    logic tim1_cc2;
    logic tim1_cc3;
    logic tim1_cc4;
    logic tim1_timer_trigger_output;
    logic tim2_cc1;
    logic tim2_cc2;
    logic tim2_timer_trigger_output;
    logic tim3_cc1;
    logic tim3_cc4;
    logic tim3_timer_trigger_output;
    logic tim4_cc4;
    logic tim4_timer_trigger_output;
    logic ext_line15;
    logic tim8_cc1;
    logic tim8_cc2;
    logic tim8_cc4;
    logic tim8_timer_trigger_output;
    logic tim5_cc1;
    logic tim5_cc3;
    logic tim5_cc4;
    logic tim5_timer_trigger_output;
  } ats_timer_evt_t;

  typedef enum logic [1:0] {
    ATS_IDLE = 2'b00,
    ATS_SAMPLE = 2'b01,
    ATS_CONVERT = 2'b11
  } ats_state_t;

  typedef struct packed {
    logic conv_start;
    logic injected;
    logic [4:0] channel;
  } ats_conv_ctl_t;

  function automatic logic [11:0] ats_smp_cycles(input logic [2:0] code);
    logic [11:0] half;
    half = `ATS_SMP_HALF_0;
    case (code)
      3'h0: half = `ATS_SMP_HALF_0;
      3'h1: half = `ATS_SMP_HALF_1;
      3'h2: half = `ATS_SMP_HALF_2;
      3'h3: half = `ATS_SMP_HALF_3;
      3'h4: half = `ATS_SMP_HALF_4;
      3'h5: half = `ATS_SMP_HALF_5;
      3'h6: half = `ATS_SMP_HALF_6;
      default: half = `ATS_SMP_HALF_7;
    endcase
    return 12'(half * `ATS_HALF_PERIOD_CYC);
  endfunction

endpackage

// *** src/ats_sample_timer.sv ***
// sampling-phase timer: counts the configured sample duration
// assumes start only while idle; code is valid in the start cycle
`timescale 1ns/10ps

module ats_sample_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [2:0] code,
  output logic active,
  output logic done
);
  import ats_pkg::*;

  logic [11:0] remain;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      remain <= 12'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        remain <= 12'(ats_smp_cycles(code) - 12'h001);
      end else if (active) begin
        if (remain == 12'h000) begin
          active <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= 12'(remain - 12'h001);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_short_sample: assert property (
    (start && !active && code == 3'h0) |=> active [*3] ##1 (!active && done))
    else $error("shortest sample time not three cycles");

  a_code2_sample: assert property (
    (start && !active && code == 3'h2) |-> ##27 active ##1 done)
    else $error("sample code 2 not 27 cycles");

endmodule

// *** src/ats_top.sv ***
// trigger selection, software start and per-channel sample time
// registers with an APB slave and a sample/convert sequencer
// assumes trigger lines and conv_done synchronous to pclk; the channel
// to convert is presented on conv_channel by the sequence logic
`timescale 1ns/10ps

module ats_top #(
  parameter int unsigned INSTANCE = 0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ats_pkg::ats_timer_evt_t trig_in,
  input wire logic [4:0] conv_channel,
  input wire logic conv_done,
  output ats_pkg::ats_conv_ctl_t conv_ctl,
  output logic sample_active,
  output logic temp_vref_enable
);
  import ats_pkg::*;

  logic [2:0] inj_sel;
  logic inj_ext_en;
  logic [2:0] reg_sel;
  logic reg_ext_en;
  logic inj_soft;
  logic reg_soft;
  logic [31:0] smp_hi;
  logic [31:0] smp_lo;
  ats_state_t state;
  ats_timer_evt_t trig_q;
  ats_timer_evt_t trig_rise;
  logic acc;
  logic wr_ctrl;
  logic [31:0] rd_val;
  logic rd_hit;
  logic inj_evt;
  logic reg_evt;
  logic inj_req;
  logic reg_req;
  logic take_inj;
  logic take_reg;
  logic [2:0] smp_field [0:17];
  logic [2:0] smp_code;
  logic smp_done;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands on the pready edge
  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && (paddr == `ATS_OFF_CTRL);

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `ATS_OFF_STATUS: rd_val = {29'h0, conv_ctl.injected, state};
      `ATS_OFF_CTRL: rd_val = {8'h00, temp_vref_enable, reg_soft,
                               inj_soft, reg_ext_en, reg_sel, 1'b0,
                               inj_ext_en, inj_sel, 12'h000};
      `ATS_OFF_SMP_HI: rd_val = smp_hi & `ATS_SMP_HI_MASK;
      `ATS_OFF_SMP_LO: rd_val = smp_lo & `ATS_SMP_LO_MASK;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_hit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_sel <= 3'h0;
      inj_ext_en <= 1'b0;
      reg_sel <= 3'h0;
      reg_ext_en <= 1'b0;
    end else if (wr_ctrl) begin
      inj_sel <= pwdata[`ATS_INJ_SEL_LSB +: 3];
      inj_ext_en <= pwdata[`ATS_INJ_EXT_EN_BIT];
      reg_sel <= pwdata[`ATS_REG_SEL_LSB +: 3];
      reg_ext_en <= pwdata[`ATS_REG_EXT_EN_BIT];
    end
  end

  // a software write of one beats a hardware clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_soft <= 1'b0;
    end else if (wr_ctrl) begin
      inj_soft <= pwdata[`ATS_INJ_SOFT_BIT];
    end else if (take_inj && inj_sel == `ATS_SW_CODE) begin
      inj_soft <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_soft <= 1'b0;
    end else if (wr_ctrl) begin
      reg_soft <= pwdata[`ATS_REG_SOFT_BIT];
    end else if (take_reg && reg_sel == `ATS_SW_CODE) begin
      reg_soft <= 1'b0;
    end
  end

  // only the first instance has the internal channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_vref_enable <= 1'b0;
    end else if (wr_ctrl) begin
      temp_vref_enable <= (INSTANCE == 0) && pwdata[`ATS_TEMP_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_hi <= `ATS_SMP_RESET;
      smp_lo <= `ATS_SMP_RESET;
    end else if (acc && pwrite) begin
      if (paddr == `ATS_OFF_SMP_HI) begin
        smp_hi <= pwdata & `ATS_SMP_HI_MASK;
      end
      if (paddr == `ATS_OFF_SMP_LO) begin
        smp_lo <= pwdata & `ATS_SMP_LO_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel sample codes
  for (genvar g = 0; g < 18; g++) begin : g_field
    if (g < 10) begin : g_lo
      assign smp_field[g] = smp_lo[g*3 +: 3];
    end else begin : g_hi
      assign smp_field[g] = smp_hi[(g-10)*3 +: 3];
    end
  end

  // channels past 17 do not exist; shortest time keeps the engine moving
  assign smp_code = (conv_channel <= 5'h11) ? smp_field[conv_channel]
                                             : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // trigger source selection; events are rising edges of the lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= '0;
    end else begin
      trig_q <= trig_in;
    end
  end

  assign trig_rise = trig_in & ~trig_q;

  always_comb begin
    reg_evt = 1'b0;
    inj_evt = 1'b0;
    if (INSTANCE < 2) begin
      case (reg_sel)
        3'h0: reg_evt = trig_rise.tim1_cc1;
        3'h1: reg_evt = trig_rise.tim1_cc2;
        3'h2: reg_evt = trig_rise.tim1_cc3;
        3'h3: reg_evt = trig_rise.tim2_cc2;
        3'h4: reg_evt = trig_rise.tim3_timer_trigger_output;
        3'h6: reg_evt = trig_rise.tim4_cc4;
        default: reg_evt = 1'b0;
      endcase
      case (inj_sel)
        3'h0: inj_evt = trig_rise.tim1_timer_trigger_output;
        3'h1: inj_evt = trig_rise.tim1_cc4;
        3'h2: inj_evt = trig_rise.tim2_timer_trigger_output;
        3'h3: inj_evt = trig_rise.tim2_cc1;
        3'h4: inj_evt = trig_rise.tim3_cc4;
        3'h5: inj_evt = trig_rise.tim4_timer_trigger_output;
        3'h6: inj_evt = trig_rise.ext_line15;
        default: inj_evt = 1'b0;
      endcase
    end else begin
      case (reg_sel)
        3'h0: reg_evt = trig_rise.tim3_cc1;
        3'h1: reg_evt = trig_rise.tim1_cc3;
        3'h2: reg_evt = trig_rise.tim8_cc1;
        3'h4: reg_evt = trig_rise.tim8_timer_trigger_output;
        3'h5: reg_evt = trig_rise.tim5_cc1;
        3'h6: reg_evt = trig_rise.tim5_cc3;
        default: reg_evt = 1'b0;
      endcase
      case (inj_sel)
        3'h0: inj_evt = trig_rise.tim1_timer_trigger_output;
        3'h1: inj_evt = trig_rise.tim1_cc4;
        3'h2: inj_evt = trig_rise.tim4_cc4;
        3'h3: inj_evt = trig_rise.tim8_cc2;
        3'h4: inj_evt = trig_rise.tim8_cc4;
        3'h5: inj_evt = trig_rise.tim5_timer_trigger_output;
        3'h6: inj_evt = trig_rise.tim5_cc4;
        default: inj_evt = 1'b0;
      endcase
    end
  end

  // timer events arriving while busy are dropped, soft bits stay pending
  assign inj_req = inj_ext_en &&
                   ((inj_sel == `ATS_SW_CODE) ? inj_soft : inj_evt);
  assign reg_req = reg_ext_en &&
                   ((reg_sel == `ATS_SW_CODE) ? reg_soft : reg_evt);
  assign take_inj = (state == ATS_IDLE) && inj_req;
  assign take_reg = (state == ATS_IDLE) && reg_req && !inj_req;

  ////////////////////////////////////////////////////////////////////////
  // sample then convert
  ats_sample_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(take_inj || take_reg),
    .code(smp_code),
    .active(sample_active),
    .done(smp_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ATS_IDLE;
    end else begin
      case (state)
        ATS_IDLE: if (take_inj || take_reg) state <= ATS_SAMPLE;
        ATS_SAMPLE: if (smp_done) state <= ATS_CONVERT;
        ATS_CONVERT: if (conv_done) state <= ATS_IDLE;
        default: state <= ATS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ctl <= '0;
    end else begin
      conv_ctl.conv_start <= (state == ATS_SAMPLE) && smp_done;
      if (take_inj || take_reg) begin
        conv_ctl.injected <= take_inj;
        conv_ctl.channel <= conv_channel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helper: sample length actually held versus what the channel asks
  logic [11:0] smp_seen;
  logic [11:0] smp_want;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_seen <= 12'h000;
      smp_want <= 12'h000;
    end else if (take_inj || take_reg) begin
      smp_seen <= 12'h000;
      smp_want <= ats_smp_cycles(smp_code);
    end else if (sample_active) begin
      smp_seen <= 12'(smp_seen + 12'h001);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_read;
    pready && !pwrite && paddr == `ATS_OFF_CTRL;
  endsequence

  a_ctrl_rsv_zero: assert property (
    s_ctrl_read |-> prdata[31:24] == 8'h00 && prdata[11:0] == 12'h000)
    else $error("control reserved bits not zero");
  a_smp_hi_rsv: assert property (
    (pready && !pwrite && paddr == `ATS_OFF_SMP_HI) |-> prdata[31:24] == 8'h00)
    else $error("sample high reserved bits not zero");
  a_smp_lo_rsv: assert property (
    (pready && !pwrite && paddr == `ATS_OFF_SMP_LO) |-> prdata[31:30] == 2'h0)
    else $error("sample low reserved bits not zero");
  a_reg_gate: assert property (
    $rose(state == ATS_SAMPLE) && !conv_ctl.injected |-> $past(reg_ext_en))
    else $error("regular start without trigger enable");
  a_reg_soft_clr: assert property (
    (take_reg && reg_sel == `ATS_SW_CODE && !wr_ctrl) |=> !reg_soft)
    else $error("regular soft start not cleared");
  a_inj_soft_clr: assert property (
    (take_inj && inj_sel == `ATS_SW_CODE && !wr_ctrl) |=> !inj_soft)
    else $error("injected soft start not cleared");
  a_temp_only_first: assert property (
    (INSTANCE != 0) |-> !temp_vref_enable)
    else $error("internal channels enabled on later instance");
  a_reg_code4_map: assert property (
    (take_reg && reg_sel == 3'h4) |->
    ((INSTANCE < 2) ? trig_rise.tim3_timer_trigger_output : trig_rise.tim8_timer_trigger_output))
    else $error("regular code 4 started by wrong source");

  sequence s_sample_end;
    $fell(sample_active);
  endsequence
  a_sample_len: assert property (
    s_sample_end |-> smp_seen == smp_want ##1 conv_ctl.conv_start)
    else $error("sample phase length differs from channel setting");
  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

endmodule

// *** verif/ats_partner.sv ***
// far side of the block: timer event lines and the converter core
// assumes the bench asks for one event pulse at a time
`timescale 1ns/10ps

module ats_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [4:0] fire_idx,
  input wire logic [3:0] lat,
  input wire ats_pkg::ats_conv_ctl_t ctl,
  output ats_pkg::ats_timer_evt_t trig_in,
  output logic conv_done
);
  import ats_pkg::*;
  logic [3:0] cnt;
  logic busy;

  // lines idle low so every pulse is a fresh rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_in <= '0;
      conv_done <= 1'b0;
      cnt <= 4'h0;
      busy <= 1'b0;
    end else begin
      trig_in <= '0;
      if (fire) begin
        trig_in[fire_idx] <= 1'b1;
      end
      conv_done <= 1'b0;
      // lat of zero answers at once, larger values stall the converter
      if (ctl.conv_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy) begin
        if (cnt == 4'h0) begin
          conv_done <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench of ats_top, first instance
// assumes the partner model answers every conversion start
`timescale 1ns/10ps
`include "ats_defines.svh"

module tb;
  import ats_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fire = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0] fire_idx = 5'h00;
  logic [4:0] conv_channel = 5'h00;
  logic [3:0] lat = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, conv_done, sample_active, temp_vref_enable;
  ats_timer_evt_t trig_in;
  ats_conv_ctl_t conv_ctl;
  int err_total = 0;
  int checks = 0;
  int hv[8] = '{3, 15, 27, 57, 83, 111, 143, 479};
  logic [31:0] lo = 32'h39C5_B1D7;
  logic [31:0] hi = 32'h00FA_C688;

  always #10 pclk = ~pclk;

  ats_top #(.INSTANCE(0)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_ctl(conv_ctl),
    .sample_active(sample_active), .temp_vref_enable(temp_vref_enable));

  ats_partner far (.pclk(pclk), .presetn(presetn), .fire(fire),
    .fire_idx(fire_idx), .lat(lat), .ctl(conv_ctl), .trig_in(trig_in),
    .conv_done(conv_done));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 1'b0, 1'b1);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("read", rd, exp);
  endtask

  task automatic pulse(input logic [4:0] idx);
    @(posedge pclk);
    fire_idx <= idx;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  task automatic quiet();
    repeat (12) begin
      @(posedge pclk);
      #1;
      chk("no_start", sample_active, 1'b0);
    end
  endtask

  task automatic conv(input int exp_n, input logic inj,
                      input logic [4:0] ch);
    int n;
    n = 0;
    while (sample_active !== 1'b1 && n < 30) begin
      @(posedge pclk);
      #1;
      n++;
    end
    n = 0;
    while (sample_active === 1'b1 && n < 600) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("sample_len", n, exp_n);
    // start pulse lands one cycle after sampling ends
    @(posedge pclk);
    #1;
    chk("conv_start", conv_ctl.conv_start, 1'b1);
    chk("injected", conv_ctl.injected, inj);
    chk("channel", conv_ctl.channel, ch);
    repeat (24) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(`ATS_OFF_CTRL, `ATS_CTRL_RESET);
    rchk(`ATS_OFF_SMP_HI, `ATS_SMP_RESET);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk("unmapped_err", er, 1'b1);
    apb(1'b1, `ATS_OFF_SMP_HI, 32'hFFFF_FFFF);
    rchk(`ATS_OFF_SMP_HI, 32'h00FF_FFFF);
    apb(1'b1, `ATS_OFF_SMP_LO, 32'hFFFF_FFFF);
    rchk(`ATS_OFF_SMP_LO, 32'h3FFF_FFFF);
    // soft bits left out so nothing starts here
    apb(1'b1, `ATS_OFF_CTRL, 32'hFF9F_FFFF);
    rchk(`ATS_OFF_CTRL, 32'h009E_F000);
    chk("temp_en", temp_vref_enable, 1'b1);
    apb(1'b1, `ATS_OFF_CTRL, 32'h0000_0000);
    // the write lands on the edge the task returns at
    @(posedge pclk);
    chk("temp_dis", temp_vref_enable, 1'b0);
    apb(1'b1, `ATS_OFF_SMP_HI, 32'h0000_0000);
    apb(1'b1, `ATS_OFF_SMP_LO, 32'h0000_0000);
  endtask

  task automatic t_trig();
    int ix[7] = '{21, 20, 19, 15, 11, 0, 10};
    for (int c = 0; c < 7; c++) begin
      if (c == 5) continue;
      conv_channel <= c[4:0];
      apb(1'b1, `ATS_OFF_CTRL, (c << 17) | (1 << 20));
      pulse(ix[(c + 1) % 7][4:0]);
      quiet();
      pulse(ix[c][4:0]);
      conv(hv[0], 1'b0, c[4:0]);
    end
    apb(1'b1, `ATS_OFF_CTRL, 32'h0000_0000);
    pulse(5'd21);
    quiet();
  endtask

  task automatic t_sample();
    logic [2:0] code;
    apb(1'b1, `ATS_OFF_SMP_LO, lo);
    apb(1'b1, `ATS_OFF_SMP_HI, hi);
    for (int ch = 0; ch < 18; ch++) begin
      code = (ch < 10) ? lo[3 * ch +: 3] : hi[3 * (ch - 10) +: 3];
      conv_channel <= ch[4:0];
      lat <= ch[3:0];
      apb(1'b1, `ATS_OFF_CTRL, (7 << 17) | (1 << 20) | (1 << 22));
      conv(hv[code], 1'b0, ch[4:0]);
      rchk(`ATS_OFF_CTRL, (7 << 17) | (1 << 20));
    end
  endtask

  task automatic t_inj();
    conv_channel <= 5'd5;
    apb(1'b1, `ATS_OFF_CTRL, (7 << 12) | (1 << 15) | (1 << 21));
    conv(hv[lo[17:15]], 1'b1, 5'd5);
    rchk(`ATS_OFF_CTRL, (7 << 12) | (1 << 15));
    // injected timer source: code 4 picks timer 3 compare 4
    apb(1'b1, `ATS_OFF_CTRL, (4 << 12) | (1 << 15));
    pulse(5'd12);
    conv(hv[lo[17:15]], 1'b1, 5'd5);
    rchk(`ATS_OFF_STATUS, 32'h0000_0004);
  endtask

  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_trig();
    t_sample();
    t_inj();
    wrap_up();
  end
endmodule
